//--- verilog/oau_core.sv
// Purpose: Operand addressing unit: decodes operand modes, forms operand addresses,
//          fetches memory operands and writes register results with size handling.
// Assumes: APB slave for software; memory port on the same clock as pclk.
// Notes:   APB accesses stall while a decode is running.
module oau_core import oau_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Operand memory read port
    output oau_mem_req_t mem_req,
    input wire logic [19:0] mem_rdata,
    input wire logic mem_ack
);
    // ==========================================================
    // Declarations
    typedef enum logic [2:0] {ST_IDLE, ST_RDSRC, ST_RDDST, ST_CALC, ST_FETCH, ST_INC} oau_state_t;

    oau_state_t state_reg;
    logic [15:0] instr_reg, ext_reg, sidx_reg, didx_reg;
    logic [19:0] result_reg, src_val_reg, src_op_reg, dst_op_reg;
    logic [19:0] src_addr_reg, dst_addr_reg;
    logic ext_on_reg, src_mem_reg, dst_mem_reg, rf_pend_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    oau_mem_req_t mem_req_reg;

    logic [3:0] src_sel, dst_sel, rf_raddr, rf_waddr;
    logic [1:0] as_mode;
    logic ad_bit, busy, acc, acc_rf, rf_we;
    logic [19:0] rf_rdata, rf_wdata;
    oau_size_t size;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [5:0] status_word;

    // ==========================================================
    // Helpers
    function automatic logic [19:0] size_mask(input logic [19:0] v, input oau_size_t sz);
        logic [19:0] r;
        r = v;
        case (sz)
            SZ_BYTE: r = {12'h000, v[7:0]};
            SZ_WORD: r = {4'h0, v[15:0]};
            SZ_AWORD: r = v;
            default: r = {4'h0, v[15:0]};
        endcase
        return r;
    endfunction

    function automatic logic [19:0] index_addr(input logic [19:0] base, input logic [15:0] idx,
                                               input logic [3:0] hi, input logic ext);
        logic [19:0] r;
        r = RST_WORD20;
        if (ext) begin
            r = base + {hi, idx};
        end else if (base[19:16] == 4'h0) begin
            r = {4'h0, base[15:0] + idx};
        end else begin
            r = base + {{4{idx[15]}}, idx};
        end
        return r;
    endfunction

    function automatic logic [19:0] step_of(input oau_size_t sz);
        logic [19:0] r;
        r = STEP_WORD;
        case (sz)
            SZ_BYTE: r = STEP_BYTE;
            SZ_WORD: r = STEP_WORD;
            SZ_AWORD: r = STEP_AWORD;
            default: r = STEP_WORD;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Decode
    always_comb begin
        src_sel = instr_reg[INS_SREG_LSB +: 4];
        dst_sel = instr_reg[INS_DREG_LSB +: 4];
        as_mode = instr_reg[INS_AS_LSB +: 2];
        ad_bit = instr_reg[INS_AD_BIT];
        // Length bit is active low; without an extension word it reads as 1
        case ({ext_on_reg ? ext_reg[EXT_AL_BIT] : 1'b1, instr_reg[INS_BW_BIT]})
            2'b11: size = SZ_BYTE;
            2'b10: size = SZ_WORD;
            2'b01: size = SZ_AWORD;
            default: size = SZ_WORD;
        endcase
    end

    assign busy = (state_reg != ST_IDLE);
    assign acc = psel & penable & ~pready_reg & ~busy;
    assign acc_rf = acc & (paddr[7:6] == OFF_CPU_REG[7:6]);

    // ==========================================================
    // Register file port steering
    always_comb begin
        rf_raddr = paddr[5:2];
        rf_we = 1'b0;
        rf_waddr = paddr[5:2];
        rf_wdata = pwdata[19:0];
        case (state_reg)
            ST_RDSRC: rf_raddr = src_sel;
            ST_RDDST: rf_raddr = dst_sel;
            ST_INC: begin
                rf_we = 1'b1;
                rf_waddr = src_sel;
                rf_wdata = src_val_reg + ((src_sel == REG_PC) ? STEP_WORD : step_of(size));
            end
            default: begin
                if (acc_rf && pwrite) begin
                    rf_we = 1'b1;
                end else if (acc && pwrite && paddr == OFF_CTRL && pwdata[CTRL_WB] && !ad_bit) begin
                    rf_we = 1'b1;
                    rf_waddr = dst_sel;
                    rf_wdata = pwdata[CTRL_SXT] ? {{12{result_reg[7]}}, result_reg[7:0]}
                                                : size_mask(result_reg, size);
                end
            end
        endcase
    end

    oau_regfile #(.DEPTH(16), .WIDTH(20)) u_regfile (
        .pclk(pclk),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .raddr(rf_raddr),
        .rdata(rf_rdata)
    );

    // ==========================================================
    // Software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_reg <= RST_WORD16;
            ext_reg <= RST_WORD16;
            sidx_reg <= RST_WORD16;
            didx_reg <= RST_WORD16;
            result_reg <= RST_WORD20;
            ext_on_reg <= 1'b0;
        end else if (acc && pwrite) begin
            case (paddr)
                OFF_CTRL: ext_on_reg <= pwdata[CTRL_EXT_ON];
                OFF_INSTR: instr_reg <= pwdata[15:0];
                OFF_EXT: ext_reg <= pwdata[15:0];
                OFF_SRC_INDEX: sidx_reg <= pwdata[15:0];
                OFF_DST_INDEX: didx_reg <= pwdata[15:0];
                OFF_RESULT: result_reg <= pwdata[19:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Operand sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            src_val_reg <= RST_WORD20;
            src_op_reg <= RST_WORD20;
            dst_op_reg <= RST_WORD20;
            src_addr_reg <= RST_WORD20;
            dst_addr_reg <= RST_WORD20;
            src_mem_reg <= 1'b0;
            dst_mem_reg <= 1'b0;
            mem_req_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (acc && pwrite && paddr == OFF_CTRL && pwdata[CTRL_START]) begin
                        state_reg <= ST_RDSRC;
                    end
                end
                ST_RDSRC: state_reg <= ST_RDDST;
                ST_RDDST: begin
                    src_val_reg <= rf_rdata;
                    state_reg <= ST_CALC;
                end
                ST_CALC: begin
                    // Destination: register or indexed; any pairing with the source
                    dst_mem_reg <= ad_bit;
                    dst_op_reg <= size_mask(rf_rdata, size);
                    dst_addr_reg <= ad_bit ? index_addr((dst_sel == REG_SR) ? RST_WORD20 : rf_rdata,
                                                        didx_reg, ext_reg[EXT_DHI_LSB +: 4],
                                                        ext_on_reg)
                                           : RST_WORD20;
                    src_mem_reg <= (as_mode != AS_REG);
                    case (as_mode)
                        AS_REG: begin
                            src_op_reg <= size_mask(src_val_reg, size);
                            src_addr_reg <= RST_WORD20;
                            state_reg <= ST_IDLE;
                        end
                        AS_INDEXED: begin
                            // PC base gives symbolic, status slot base gives absolute
                            src_addr_reg <= index_addr((src_sel == REG_SR) ? RST_WORD20
                                                                           : src_val_reg,
                                                       sidx_reg, ext_reg[EXT_SHI_LSB +: 4],
                                                       ext_on_reg);
                            mem_req_reg.rd <= 1'b1;
                            mem_req_reg.addr <= index_addr((src_sel == REG_SR) ? RST_WORD20
                                                                               : src_val_reg,
                                                           sidx_reg, ext_reg[EXT_SHI_LSB +: 4],
                                                           ext_on_reg);
                            state_reg <= ST_FETCH;
                        end
                        default: begin
                            // Indirect and autoincrement: register is the pointer;
                            // on the PC autoincrement is the immediate form
                            src_addr_reg <= src_val_reg;
                            mem_req_reg.rd <= 1'b1;
                            mem_req_reg.addr <= src_val_reg;
                            state_reg <= ST_FETCH;
                        end
                    endcase
                end
                ST_FETCH: begin
                    if (mem_ack) begin
                        src_op_reg <= size_mask(mem_rdata, size);
                        mem_req_reg.rd <= 1'b0;
                        state_reg <= (as_mode == AS_AUTOINC) ? ST_INC : ST_IDLE;
                    end
                end
                ST_INC: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Status word
    // Bit 3 is spare; size sits at 5:4 for software masks
    always_comb begin
        status_word = 6'h00;
        status_word[0] = busy;
        status_word[1] = src_mem_reg;
        status_word[2] = dst_mem_reg;
        status_word[5:4] = size;
    end

    // ==========================================================
    // APB read data and answer
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = RST_WORD32;
        case (paddr)
            OFF_CTRL: rd_mux[CTRL_EXT_ON] = ext_on_reg;
            OFF_STATUS: rd_mux[5:0] = status_word;
            OFF_INSTR: rd_mux[15:0] = instr_reg;
            OFF_EXT: rd_mux[15:0] = ext_reg;
            OFF_SRC_INDEX: rd_mux[15:0] = sidx_reg;
            OFF_DST_INDEX: rd_mux[15:0] = didx_reg;
            OFF_RESULT: rd_mux[19:0] = result_reg;
            OFF_SRC_OPERAND: rd_mux[19:0] = src_op_reg;
            OFF_SRC_ADDR: rd_mux[19:0] = src_addr_reg;
            OFF_DST_ADDR: rd_mux[19:0] = dst_addr_reg;
            OFF_DST_OPERAND: rd_mux[19:0] = dst_op_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= RST_WORD32;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            rf_pend_reg <= 1'b0;
        end else if (pready_reg) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (acc_rf && !pwrite) begin
            // Register file read needs one extra cycle for its output flop
            if (rf_pend_reg) begin
                prdata_reg <= {12'h000, rf_rdata};
                pready_reg <= 1'b1;
                rf_pend_reg <= 1'b0;
            end else begin
                rf_pend_reg <= 1'b1;
            end
        end else if (acc) begin
            prdata_reg <= pwrite ? RST_WORD32 : (rd_hit ? rd_mux : RST_WORD32);
            pready_reg <= 1'b1;
            pslverr_reg <= ~rd_hit & ~acc_rf;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mem_req = mem_req_reg;
endmodule // oau_core

//--- verilog/oau_regfile.sv
// Purpose: Shared constants and types, plus the 16 x 20-bit CPU register file.
// Assumes: One clock (pclk), asynchronous active-low reset (presetn).
// Notes:   Register file read data comes out of a flop, one cycle after the address.
// How it works
// - Decode seven source, four destination modes
// - Register mode: register contents are operand
// - Indexed: address is register plus index
// - Symbolic: indexed mode with program counter base
// - Absolute: status slot base, word is address
// - Indirect: register points at source operand
// - Autoincrement: pointer plus 1, 2 or 4
// - Immediate: autoincrement on program counter
// - Byte write clears destination bits 19:8
// - Word write clears destination bits 19:16
// - Address-word write keeps all 20 bits
// - Sign extend copies bit 7 upward
// - Length bit with byte bit 01 selects 20-bit
// - Low base: 16-bit sum, upper bits cleared
// - High base: sign-extended index, 20-bit sum
// - Index words follow instruction, both operands
// - Any source/destination mode pair, full range
package oau_pkg;
    // ==========================================================
    // APB register offsets
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_INSTR = 8'h08;
    localparam logic [7:0] OFF_EXT = 8'h0C;
    localparam logic [7:0] OFF_SRC_INDEX = 8'h10;
    localparam logic [7:0] OFF_DST_INDEX = 8'h14;
    localparam logic [7:0] OFF_RESULT = 8'h18;
    localparam logic [7:0] OFF_SRC_OPERAND = 8'h1C;
    localparam logic [7:0] OFF_SRC_ADDR = 8'h20;
    localparam logic [7:0] OFF_DST_ADDR = 8'h24;
    localparam logic [7:0] OFF_DST_OPERAND = 8'h28;
    localparam logic [7:0] OFF_CPU_REG = 8'h40;
    // ==========================================================
    // Control bits and instruction field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_WB = 1;
    localparam int CTRL_SXT = 2;
    localparam int CTRL_EXT_ON = 3;
    localparam int INS_SREG_LSB = 8;
    localparam int INS_AD_BIT = 7;
    localparam int INS_BW_BIT = 6;
    localparam int INS_AS_LSB = 4;
    localparam int INS_DREG_LSB = 0;
    localparam int EXT_SHI_LSB = 7;
    localparam int EXT_AL_BIT = 6;
    localparam int EXT_DHI_LSB = 0;
    // ==========================================================
    // Modes, special registers, increments, reset values
    localparam logic [1:0] AS_REG = 2'h0;
    localparam logic [1:0] AS_INDEXED = 2'h1;
    localparam logic [1:0] AS_INDIRECT = 2'h2;
    localparam logic [1:0] AS_AUTOINC = 2'h3;
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [19:0] STEP_BYTE = 20'h0_0001;
    localparam logic [19:0] STEP_WORD = 20'h0_0002;
    localparam logic [19:0] STEP_AWORD = 20'h0_0004;
    localparam logic [15:0] RST_WORD16 = 16'h0000;
    localparam logic [19:0] RST_WORD20 = 20'h0_0000;
    localparam logic [31:0] RST_WORD32 = 32'h0000_0000;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_AWORD} oau_size_t;

    typedef struct packed {
        logic rd;
        logic [19:0] addr;
    } oau_mem_req_t;
endpackage

module oau_regfile #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 20
) (
    // Clock
    input wire logic pclk,
    // Write port
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Registered read port
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk) begin
        rdata <= mem[raddr];
    end
endmodule // oau_regfile

//--- bench/oau_core_sva.sv
// Purpose: Port-level checker for oau_core
// Assumes: Single pclk domain, presetn active low
// Notes: Bound to every oau_core instance
module oau_core_sva import oau_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Memory port
    input wire oau_mem_req_t mem_req,
    input wire logic [19:0] mem_rdata,
    input wire logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Helpers
    logic [3:0] since_start;
    logic unmapped;
    assign unmapped = (paddr >= 8'h2c && paddr < 8'h40) || paddr >= 8'h80;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_start <= 4'hf;
        end else if (pready && pwrite && paddr == OFF_CTRL && pwdata[0]) begin
            since_start <= 4'h0;
        end else if (since_start != 4'hf) begin
            since_start <= since_start + 4'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    a_ready_bounded: assert property (psel && penable && !pready |-> ##[1:40] pready)
        else $error("access never answered");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready && unmapped |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (pready && !unmapped && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_fetch_holds: assert property (mem_req.rd && !mem_ack |=> mem_req.rd && $stable(mem_req.addr))
        else $error("operand request changed before ack");
    a_fetch_ends: assert property (mem_req.rd && mem_ack |=> !mem_req.rd)
        else $error("operand request not dropped after ack");
    a_fetch_after_start: assert property ($rose(mem_req.rd) |-> since_start inside {[1:6]})
        else $error("operand fetch not tied to a decode start");
endmodule // oau_core_sva

bind oau_core oau_core_sva u_oau_core_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

//--- bench/oau_mem_model.sv
// Purpose: Operand memory answering oau_core reads
// Assumes: Data word is address xor a fixed pattern
// Notes: Alternates prompt and slow answers; data toggles when idle
module oau_mem_model import oau_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory port
    input wire oau_mem_req_t mem_req,
    output logic [19:0] mem_rdata,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Responder
    logic [2:0] wait_cnt;
    logic slow;
    logic done;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 20'h0_0000;
            wait_cnt <= 3'h0;
            slow <= 1'b0;
            done <= 1'b0;
        end else begin
            mem_ack <= 1'b0;
            // Stale data never looks valid
            mem_rdata <= ~mem_rdata;
            if (!mem_req.rd) begin
                done <= 1'b0;
                wait_cnt <= 3'h0;
            end else if (!done) begin
                if (wait_cnt == (slow ? 3'h4 : 3'h0)) begin
                    mem_ack <= 1'b1;
                    mem_rdata <= mem_req.addr ^ 20'ha_5a5a;
                    done <= 1'b1;
                    slow <= !slow;
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
        end
    end
endmodule // oau_mem_model

//--- bench/tb_operand_addressing_unit.sv
// Purpose: Self-checking bench for oau_core
// Assumes: APB master waiting on pready, memory model on far side
// Notes: Expected values come from a behavioural address model
module tb_operand_addressing_unit import oau_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, qerr;
    logic bw, ad, al, eon;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, r, seed;
    logic [19:0] mem_rdata, base, dbase, res, exp, ea_s, v;
    logic [15:0] idx, didx;
    logic [3:0] src;
    logic [1:0] mode, sz;
    oau_mem_req_t mem_req;
    int failures, checks_done, k;

    oau_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    oau_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [19:0] ea(input logic [19:0] b, input logic [15:0] x);
        if (b[19:16] == 4'h0) return {4'h0, b[15:0] + x};
        return b + {{4{x[15]}}, x};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(40 * 30000);
        failures++;
        complete_run();
    end
    // ==========================================================
    // Tests
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h491e_d310;
        failures = 0;
        checks_done = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 8; k++) begin
            sz = 2'(k % 4);
            r = xs();
            v = r[19:0];
            r = xs();
            res = r[19:0];
            apb(1'b1, OFF_CPU_REG + 8'h14, xs());
            apb(1'b1, OFF_CPU_REG + 8'h24, {12'h000, v});
            apb(1'b1, OFF_INSTR, {16'h0000, 8'h09, 1'b0, sz != 2'd1, 6'h05});
            apb(1'b1, OFF_EXT, {25'h0, sz != 2'd2, 6'h00});
            apb(1'b1, OFF_RESULT, {12'h000, res});
            apb(1'b1, OFF_CTRL, {28'h0, 1'b1, sz == 2'd3, 2'b10});
            case (sz)
                2'd0: exp = {12'h000, res[7:0]};
                2'd1: exp = {4'h0, res[15:0]};
                2'd2: exp = res;
                default: exp = {{12{res[7]}}, res[7:0]};
            endcase
            apb(1'b0, OFF_CPU_REG + 8'h14, 32'h0);
            chk(q, {12'h000, exp});
            apb(1'b0, OFF_CPU_REG + 8'h24, 32'h0);
            chk(q, {12'h000, v});
        end
        $display("test write-back done");
        for (k = 0; k < 32; k++) begin
            mode = 2'(k % 4);
            r = xs();
            case (r[1:0])
                2'd0: src = 4'h0;
                2'd1: src = 4'h2;
                2'd2: src = 4'h5;
                default: src = 4'h9;
            endcase
            {eon, al, ad, bw} = {mode != 2'd1 && r[5], r[4:2]};
            base = {r[6] ? r[11:8] : 4'h0, r[31:16]};
            r = xs();
            dbase = r[19:0];
            r = xs();
            {didx, idx} = r;
            sz = (eon && !al && bw) ? 2'd2 : (bw ? 2'd0 : 2'd1);
            apb(1'b1, OFF_CPU_REG + {2'b00, src, 2'b00}, {12'h000, base});
            apb(1'b1, OFF_CPU_REG + 8'h30, {12'h000, dbase});
            apb(1'b1, OFF_INSTR, {16'h0000, 4'h0, src, ad, bw, mode, 4'hc});
            apb(1'b1, OFF_EXT, {25'h0, al, 6'h00});
            apb(1'b1, OFF_SRC_INDEX, {16'h0000, idx});
            apb(1'b1, OFF_DST_INDEX, {16'h0000, didx});
            apb(1'b1, OFF_CTRL, {28'h0, eon, 3'b001});
            ea_s = (mode == 2'd1) ? ea(src == 4'h2 ? 20'h0_0000 : base, idx) : base;
            apb(1'b0, OFF_STATUS, 32'h0);
            chk(q & 32'h0000_0037, {26'h0, sz, 1'b0, ad, mode != 2'd0, 1'b0});
            if (mode != 2'd0) begin
                apb(1'b0, OFF_SRC_ADDR, 32'h0);
                chk(q, {12'h000, ea_s});
            end
            v = (mode == 2'd0) ? base : ea_s ^ 20'ha_5a5a;
            apb(1'b0, OFF_SRC_OPERAND, 32'h0);
            chk(q & 32'h0000_00ff, {24'h00_0000, v[7:0]});
            if (ad) begin
                apb(1'b0, OFF_DST_ADDR, 32'h0);
                chk(q, {12'h000, eon ? dbase + {4'h0, didx} : ea(dbase, didx)});
            end
            v = {12'h000, dbase[7:0]};
            if (sz == 2'd1) v = {4'h0, dbase[15:0]};
            if (sz == 2'd2) v = dbase;
            apb(1'b0, OFF_DST_OPERAND, 32'h0);
            chk(q, {12'h000, v});
            v = (src == 4'h0) ? 20'h0_0002 : 20'h0_0001 << sz;
            apb(1'b0, OFF_CPU_REG + {2'b00, src, 2'b00}, 32'h0);
            chk(q, {12'h000, mode == 2'd3 ? base + v : base});
        end
        $display("test decode done");
        apb(1'b0, 8'h30, 32'h0);
        chk({qerr, q[30:0]}, 32'h8000_0000);
        apb(1'b1, 8'h84, xs());
        chk({31'h0, qerr}, 32'h0000_0001);
        $display("test unmapped done");
        complete_run();
    end
endmodule // tb_operand_addressing_unit
